// ==== verilog/synth_pll_config_regs.sv ====
// Synthesizer setup register bank behind an AHB-Lite slave
`include "synth_pll_defs.svh"

module synth_pll_config_regs (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  // AHB-Lite slave
  input  wire synth_pll_pkg::ahb_req_t   ahb_req,
  input  wire logic [31:0]               hwdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Synthesizer controls
  output synth_pll_pkg::synth_ctrl_t     synth_ctrl
);
  import synth_pll_pkg::*;

  logic [31:0] synth_setup;
  logic [31:0] synth_divider_ratios;
  logic        write_pending;
  logic [5:0]  write_index;

  // Address phase decode
  function automatic logic index_hit(input logic [31:0] addr, input logic [5:0] idx);
    index_hit = (addr[`ADDR_MSB:`INDEX_MSB+1] == '0) &&
                (addr[`INDEX_MSB:`INDEX_LSB] == idx) &&
                (addr[`INDEX_LSB-1:0] == 2'h0);
  endfunction

  wire logic       phase_valid = ahb_req.hsel && ahb_req.hready &&
                                 ahb_req.htrans[`HTRANS_NONSEQ_BIT];
  wire logic       word_size   = (ahb_req.hsize == `HSIZE_WORD);
  wire logic       in_window   = (ahb_req.haddr[31:`ADDR_MSB+1] == '0);
  wire logic [5:0] addr_index  = in_window && index_hit(ahb_req.haddr,
                                   ahb_req.haddr[`INDEX_MSB:`INDEX_LSB]) ?
                                   ahb_req.haddr[`INDEX_MSB:`INDEX_LSB] : 6'h3f;
  wire logic       start_write = phase_valid && ahb_req.hwrite && word_size;
  wire logic       start_read  = phase_valid && !ahb_req.hwrite;

  // Data phase write strobes
  wire logic write_setup  = write_pending && (write_index == `SETUP_INDEX);
  wire logic write_ratios = write_pending && (write_index == `RATIOS_INDEX);

  // Register contents with the write in flight forwarded
  wire logic [31:0] setup_now  = write_setup  ? hwdata : synth_setup;
  wire logic [31:0] ratios_now = write_ratios ? hwdata : synth_divider_ratios;

  // Status shows reserved codes currently programmed
  wire logic div_reserved  = (setup_now[`DIV_SEL_MSB:`DIV_SEL_LSB] > `DIV_X4);
  wire logic xtal_reserved = (setup_now[`XTAL_MSB:`XTAL_LSB] != `XTAL_NORMAL) &&
                             (setup_now[`XTAL_MSB:`XTAL_LSB] != `XTAL_HIGH);
  logic [31:0] status_now;
  always_comb begin
    status_now = `STATUS_RESET;
    status_now[`STAT_DIV_RSVD_BIT]  = div_reserved;
    status_now[`STAT_XTAL_RSVD_BIT] = xtal_reserved;
  end

  // Read data select, unmapped reads give zero
  wire logic [31:0] read_mux =
    (addr_index == `SETUP_INDEX)  ? setup_now  :
    (addr_index == `RATIOS_INDEX) ? ratios_now :
    (addr_index == `STATUS_INDEX) ? status_now : 32'h00000000;

  // Decoded next control values
  wire logic [2:0] div_code  = setup_now[`DIV_SEL_MSB:`DIV_SEL_LSB];
  wire logic [1:0] xtal_code = setup_now[`XTAL_MSB:`XTAL_LSB];
  synth_ctrl_t next_synth_ctrl;
  always_comb begin
    next_synth_ctrl                          = '0;
    next_synth_ctrl.clock_out_divide_sel     = div_code;
    next_synth_ctrl.clock_ratio.times_two    = (div_code == `DIV_X2);
    next_synth_ctrl.clock_ratio.quarter      = (div_code == `DIV_QUARTER);
    next_synth_ctrl.clock_ratio.half         = (div_code == `DIV_HALF);
    next_synth_ctrl.clock_ratio.times_one    = (div_code == `DIV_X1);
    next_synth_ctrl.clock_ratio.times_four   = (div_code == `DIV_X4);
    next_synth_ctrl.clock_ratio.reserved     = div_reserved;
    next_synth_ctrl.osc_band_select          = setup_now[`BAND_BIT];
    next_synth_ctrl.clock_buffer_on          = setup_now[`BUFFER_BIT];
    next_synth_ctrl.crystal_drive_current    = xtal_code;
    next_synth_ctrl.crystal_drive_high       = (xtal_code == `XTAL_HIGH);
    next_synth_ctrl.crystal_drive_reserved   = xtal_reserved;
    next_synth_ctrl.charge_pump_current_sel  = setup_now[`PUMP_BIT];
    next_synth_ctrl.integer_n_mode           = setup_now[`INT_MODE_BIT];
    next_synth_ctrl.synth_power_save         = setup_now[`POWER_SAVE_BIT];
    next_synth_ctrl.feedback_integer_ratio   = ratios_now[`FB_MSB:`FB_LSB];
    next_synth_ctrl.reference_ratio          = ratios_now[`REF_MSB:`REF_LSB];
  end

  // Reset value of the decoded controls
  localparam logic [31:0] SETUP_INIT  = `SETUP_RESET;
  localparam logic [31:0] RATIOS_INIT = `RATIOS_RESET;
  synth_ctrl_t reset_ctrl;
  always_comb begin
    reset_ctrl                               = '0;
    reset_ctrl.clock_out_divide_sel          = SETUP_INIT[`DIV_SEL_MSB:`DIV_SEL_LSB];
    reset_ctrl.clock_ratio.times_one         =
      (SETUP_INIT[`DIV_SEL_MSB:`DIV_SEL_LSB] == `DIV_X1);
    reset_ctrl.osc_band_select               = SETUP_INIT[`BAND_BIT];
    reset_ctrl.clock_buffer_on               = SETUP_INIT[`BUFFER_BIT];
    reset_ctrl.crystal_drive_current         = SETUP_INIT[`XTAL_MSB:`XTAL_LSB];
    reset_ctrl.crystal_drive_high            =
      (SETUP_INIT[`XTAL_MSB:`XTAL_LSB] == `XTAL_HIGH);
    reset_ctrl.charge_pump_current_sel       = SETUP_INIT[`PUMP_BIT];
    reset_ctrl.integer_n_mode                = SETUP_INIT[`INT_MODE_BIT];
    reset_ctrl.synth_power_save              = SETUP_INIT[`POWER_SAVE_BIT];
    reset_ctrl.feedback_integer_ratio        = RATIOS_INIT[`FB_MSB:`FB_LSB];
    reset_ctrl.reference_ratio               = RATIOS_INIT[`REF_MSB:`REF_LSB];
  end

  // Address phase capture
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      write_pending <= 1'b0;
      write_index   <= 6'h3f;
    end else if (ahb_req.hready) begin
      write_pending <= start_write;
      write_index   <= addr_index;
    end
  end

  // Register storage, reserved bits kept as written
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      synth_setup          <= `SETUP_RESET;
      synth_divider_ratios <= `RATIOS_RESET;
    end else begin
      synth_setup          <= setup_now;
      synth_divider_ratios <= ratios_now;
    end
  end

  // Registered bus answer, low in reset, no wait state after
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp     <= `HRESP_OKAY;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      if (start_read) begin
        hrdata <= read_mux;
      end
    end
  end

  // Controls to the synthesizer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      synth_ctrl <= reset_ctrl;
    end else begin
      synth_ctrl <= next_synth_ctrl;
    end
  end

endmodule

// ==== verilog/synth_pll_defs.svh ====
// Constants for the synthesizer setup register bank
`ifndef SYNTH_PLL_DEFS_SVH
`define SYNTH_PLL_DEFS_SVH

// Register indices and address bit positions
`define SETUP_INDEX       6'h03
`define RATIOS_INDEX      6'h04
`define STATUS_INDEX      6'h10
`define INDEX_LSB         2
`define INDEX_MSB         7
`define ADDR_MSB          11

// Reset values
`define SETUP_RESET       32'h698c0000
`define RATIOS_RESET      32'h00c00080
`define STATUS_RESET      32'h00000000

// Setup register fields
`define DIV_SEL_MSB       31
`define DIV_SEL_LSB       29
`define BAND_BIT          28
`define BUFFER_BIT        24
`define XTAL_MSB          20
`define XTAL_LSB          19
`define PUMP_BIT          9
`define INT_MODE_BIT      3
`define POWER_SAVE_BIT    2

// Ratio register fields
`define FB_MSB            27
`define FB_LSB            13
`define REF_MSB           12
`define REF_LSB           3

// Status register fields
`define STAT_DIV_RSVD_BIT 0
`define STAT_XTAL_RSVD_BIT 1

// Field codes
`define DIV_X2            3'h0
`define DIV_QUARTER       3'h1
`define DIV_HALF          3'h2
`define DIV_X1            3'h3
`define DIV_X4            3'h4
`define XTAL_NORMAL       2'h1
`define XTAL_HIGH         2'h3

// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD        3'h2
`define HRESP_OKAY        1'b0

`endif

// ==== verilog/synth_pll_pkg.sv ====
// Types for the synthesizer setup register bank
package synth_pll_pkg;

  // Output clock ratio, one-hot, reserved codes in their own flag
  typedef struct packed {
    logic times_two;
    logic quarter;
    logic half;
    logic times_one;
    logic times_four;
    logic reserved;
  } clock_ratio_t;

  // Settings handed to the analog synthesizer
  typedef struct packed {
    logic [2:0]   clock_out_divide_sel;
    clock_ratio_t clock_ratio;
    logic         osc_band_select;
    logic         clock_buffer_on;
    logic [1:0]   crystal_drive_current;
    logic         crystal_drive_high;
    logic         crystal_drive_reserved;
    logic         charge_pump_current_sel;
    logic         integer_n_mode;
    logic         synth_power_save;
    logic [14:0]  feedback_integer_ratio;
    logic [9:0]   reference_ratio;
  } synth_ctrl_t;

  // AHB-Lite request side
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;

endpackage

// ==== testbench/synth_pll_config_regs_chk.sv ====
// Assertion checker for the synthesizer setup register bank
module synth_pll_config_regs_chk (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    resetn,
  // Bus
  input wire synth_pll_pkg::ahb_req_t ahb_req,
  input wire logic [31:0]             hwdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [31:0]             hrdata,
  // Controls
  input wire synth_pll_pkg::synth_ctrl_t synth_ctrl
);
  timeunit 1ns;
  timeprecision 100ps;
  import synth_pll_pkg::*;
  logic wr_q, wr_s, wr_r;
  wire  wr_ok = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & ahb_req.hwrite
                & (ahb_req.hsize == 3'h2);
  always_ff @(posedge core_clk) begin
    wr_q <= resetn & wr_ok;
    wr_s <= resetn & wr_ok & (ahb_req.haddr == 32'h0000000c);
    wr_r <= resetn & wr_ok & (ahb_req.haddr == 32'h00000010);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_ready_okay: assert property ($past(resetn) |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_ratio_onehot: assert property ($onehot(synth_ctrl.clock_ratio))
    else $error("ratio flags not one-hot");
  chk_ratio_decode: assert property (
    synth_ctrl.clock_ratio == ((synth_ctrl.clock_out_divide_sel > 3'h4) ?
                               6'h01 : 6'h20 >> synth_ctrl.clock_out_divide_sel))
    else $error("ratio decode wrong");
  chk_xtal_decode: assert property (
    {synth_ctrl.crystal_drive_high, synth_ctrl.crystal_drive_reserved} ==
    {&synth_ctrl.crystal_drive_current, !synth_ctrl.crystal_drive_current[0]})
    else $error("crystal decode wrong");
  chk_setup_load: assert property (
    wr_s |=> {synth_ctrl.clock_out_divide_sel, synth_ctrl.osc_band_select,
              synth_ctrl.clock_buffer_on, synth_ctrl.crystal_drive_current} ==
             $past({hwdata[31:28], hwdata[24], hwdata[20:19]}))
    else $error("setup fields not loaded");
  chk_mode_load: assert property (
    wr_s |=> {synth_ctrl.charge_pump_current_sel, synth_ctrl.integer_n_mode,
              synth_ctrl.synth_power_save} == $past({hwdata[9], hwdata[3:2]}))
    else $error("mode bits not loaded");
  chk_ratio_load: assert property (
    wr_r |=> {synth_ctrl.feedback_integer_ratio, synth_ctrl.reference_ratio} ==
             $past(hwdata[27:3]))
    else $error("ratios not loaded");
  chk_ctrl_hold: assert property (!wr_q |=> $stable(synth_ctrl))
    else $error("controls changed without write");
  cover property (wr_s);
  cover property (wr_r);
  cover property (synth_ctrl.clock_ratio.reserved);
endmodule

bind synth_pll_config_regs synth_pll_config_regs_chk u_synth_pll_config_regs_chk (
  .core_clk(core_clk), .resetn(resetn), .ahb_req(ahb_req), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .synth_ctrl(synth_ctrl));

// ==== testbench/testbench.sv ====
// Self-checking bench for the synthesizer setup register bank
`include "synth_pll_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import synth_pll_pkg::*;
  localparam logic [31:0] SA = {24'h0, `SETUP_INDEX, 2'b00};
  localparam logic [31:0] RA = {24'h0, `RATIOS_INDEX, 2'b00};
  localparam logic [31:0] STA = {24'h0, `STATUS_INDEX, 2'b00};
  localparam logic [31:0] SR = `SETUP_RESET;
  logic        core_clk, resetn = 1'b0;
  ahb_req_t    req = '0, bus;
  logic [31:0] hwdata = '0, hrdata, rd, d;
  logic        hreadyout, hresp;
  synth_ctrl_t ctl;
  logic [31:0] rv [2] = '{32'h0fffe008, 32'h00003ff8};
  int          num_errors = 0, comparisons = 0;
  assign bus = '{req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, hreadyout};
  synth_pll_config_regs u_synth_pll_config_regs (.core_clk(core_clk), .resetn(resetn),
    .ahb_req(bus), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .synth_ctrl(ctl));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One single transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, wd, input logic [2:0] sz = 3'h2);
    req <= '{1'b1, a, 2'b10, wr, sz, 1'b0};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    req <= '0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rst_chk();
    xfer(0, SA, 0);
    check(rd, `SETUP_RESET);
    xfer(0, RA, 0);
    check(rd, `RATIOS_RESET);
    check({ctl.feedback_integer_ratio, ctl.reference_ratio}, {15'h600, 10'h010});
  endtask
  initial begin
    #20us;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rst_chk();
    for (int c = 0; c < 8; c++) begin
      d = {c[2:0], SR[28:0]};
      xfer(1, SA, d);
      xfer(0, SA, 0);
      check(rd, d);
      check(ctl.clock_ratio, c < 5 ? 6'h20 >> c : 6'h01);
      xfer(0, STA, 0);
      check(rd, {30'h0, 1'b0, c > 4});
    end
    for (int c = 0; c < 4; c++) begin
      d = c[0] ? SR ^ 32'h1100020c : SR;
      d[20:19] = c[1:0];
      xfer(1, SA, d);
      xfer(0, SA, 0);
      check(ctl.crystal_drive_current, c);
      check({ctl.crystal_drive_high, ctl.crystal_drive_reserved}, {c == 3, !c[0]});
      check({ctl.osc_band_select, ctl.clock_buffer_on}, c[0] ? 2'h2 : 2'h1);
      check({ctl.charge_pump_current_sel, ctl.integer_n_mode, ctl.synth_power_save},
            c[0] ? 3'h7 : 3'h0);
      xfer(0, STA, 0);
      check(rd, {30'h0, !c[0], 1'b0});
    end
    foreach (rv[i]) begin
      xfer(1, RA, rv[i]);
      xfer(0, RA, 0);
      check(rd, rv[i]);
      check({ctl.feedback_integer_ratio, ctl.reference_ratio}, rv[i][27:3]);
    end
    xfer(1, SA, 32'h0, 3'h0);
    xfer(0, SA, 0);
    check(rd, d);
    xfer(1, 32'h100, 32'hffffffff);
    xfer(0, 32'h100, 0);
    check(rd, 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rst_chk();
    end_of_test();
  end
endmodule
